/* File: src/acs_map.svh */
/*
 channel map constants for the converter channel-select block.
 assumes inclusion by the package and the design files only.
*/
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_NUM_CHANNELS 32
`define ACS_NUM_USER_CHANNELS 30
`define ACS_NUM_GROUPS 5
`define ACS_CODE_WIDTH 5
`define ACS_CH_CORE_SUPPLY 5'h0
`define ACS_CH_DIE_TEMP 5'h1f
`define ACS_CH_GROUP_FIRST 5'h1
`define ACS_CH_GROUP_LAST 5'hf
`define ACS_SEL_RESET 32'h0000_0001
`endif

/* File: src/acs_pkg.sv */
/*
 types for the converter channel-select block.
 assumes acs_map.svh is on the include path.
*/
`include "acs_map.svh"
package acs_pkg;
	typedef logic [`ACS_CODE_WIDTH-1:0] acs_code_t;
	typedef logic [`ACS_NUM_CHANNELS-1:0] acs_onehot_t;
	// source type of the selected channel
	typedef enum logic [2:0] {
		ACS_SRC_SUPPLY = 3'h0,
		ACS_SRC_VOLT = 3'h1,
		ACS_SRC_CURR = 3'h3,
		ACS_SRC_THERM = 3'h2,
		ACS_SRC_DIETEMP = 3'h6,
		ACS_SRC_SPARE = 3'h7
	} acs_src_e;
	// request from user fabric
	typedef struct packed {
		acs_code_t code;
		logic tempStrobe;
	} acs_req_s;
	// registered selection toward the analog mux
	typedef struct packed {
		acs_onehot_t sel;
		acs_src_e src;
		logic [2:0] group;
		logic groupValid;
		logic dieTempStrobe;
		logic groupTempStrobe;
	} acs_sel_s;
endpackage

/* File: src/acs_decode.sv */
/*
 decodes a 5-bit channel code into source type and group index.
 assumes a binary code from the top module, purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_decode (
	input wire acs_pkg::acs_code_t code,
	output acs_pkg::acs_src_e src,
	output logic [2:0] group,
	output logic groupValid
);
	import acs_pkg::*;
	logic [4:0] idx;
	// group n owns channels 3n+1..3n+3
	always_comb begin
		idx = code - 5'h1;
		src = ACS_SRC_SPARE;
		group = 3'h0;
		groupValid = 1'b0;
		if (code == `ACS_CH_CORE_SUPPLY) begin
			src = ACS_SRC_SUPPLY;
		end else if (code == `ACS_CH_DIE_TEMP) begin
			src = ACS_SRC_DIETEMP;
		end else if (code <= `ACS_CH_GROUP_LAST) begin
			group = 3'(idx / 5'h3);
			groupValid = 1'b1;
			case (idx % 5'h3)
				5'h0: src = ACS_SRC_VOLT;
				5'h1: src = ACS_SRC_CURR;
				default: src = ACS_SRC_THERM;
			endcase
		end
	end
endmodule // acs_decode
`default_nettype wire

/* File: src/acs_channel_select.sv */
/*
 channel selection for the 32:1 converter input multiplexer.
 assumes user fabric on sys_clk drives the code and strobe, holding them per conversion.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_channel_select (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire acs_pkg::acs_req_s req,
	output acs_pkg::acs_sel_s sel
);
	import acs_pkg::*;
	acs_src_e srcD;
	logic [2:0] groupD;
	logic groupValidD;
	// registered selection, one flop group per concern
	acs_onehot_t selBitsQ;
	acs_src_e srcQ;
	logic [2:0] groupQ;
	logic groupValidQ;
	logic dieStrobeQ;
	logic groupStrobeQ;
	// strobe requests already gated by the channel they belong to
	logic dieStrobeD;
	logic groupStrobeD;
	// high once the outputs reflect a request taken out of reset
	logic liveQ;

	////////////////////////////////////////////////////////////////
	// decode of the code (same-clock input, no synchroniser)
	acs_decode uDecode (
		.code(req.code),
		.src(srcD),
		.group(groupD),
		.groupValid(groupValidD)
	);

	////////////////////////////////////////////////////////////////
	// one-hot mux select, one bit per channel
	genvar gi;
	generate
		for (gi = 0; gi < `ACS_NUM_CHANNELS; gi++) begin : gSel
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					selBitsQ[gi] <= 1'(`ACS_SEL_RESET >> gi);
				end else begin
					selBitsQ[gi] <= (req.code == 5'(gi));
				end
			end
		end
	endgenerate

	// strobe gating: a strobe only reaches the sensor that the code selects
	assign dieStrobeD = req.tempStrobe && (req.code == `ACS_CH_DIE_TEMP);
	assign groupStrobeD = req.tempStrobe && (srcD == ACS_SRC_THERM);

	// source classification of the selected channel
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			srcQ <= ACS_SRC_SUPPLY;
			groupQ <= 3'h0;
			groupValidQ <= 1'b0;
		end else begin
			srcQ <= srcD;
			groupQ <= groupD;
			groupValidQ <= groupValidD;
		end
	end

	// temperature strobes, registered so they line up with the select
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dieStrobeQ <= 1'b0;
			groupStrobeQ <= 1'b0;
		end else begin
			dieStrobeQ <= dieStrobeD;
			groupStrobeQ <= groupStrobeD;
		end
	end

	// the edge that releases reset still sees the flops in reset, so the
	// first request is only reflected from the following edge on
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			liveQ <= 1'b0;
		end else begin
			liveQ <= 1'b1;
		end
	end

	// pack the registered fields toward the analog mux
	assign sel = '{
		sel: selBitsQ,
		src: srcQ,
		group: groupQ,
		groupValid: groupValidQ,
		dieTempStrobe: dieStrobeQ,
		groupTempStrobe: groupStrobeQ
	};

	////////////////////////////////////////////////////////////////
	// checks
	sequence sCodeIs(int c);
		liveQ && req.code == 5'(c);
	endsequence

	// code names input k (0 voltage, 1 current, 2 thermal) of group g
	sequence sGroupCode(int g, int k);
		liveQ && req.code == 5'(3 * g + k + 1);
	endsequence

	// temperature strobe raised together with code c
	sequence sStrobeWith(int c);
		liveQ && req.tempStrobe && req.code == 5'(c);
	endsequence

	// no temperature strobe requested
	sequence sStrobeIdle;
		liveQ && !req.tempStrobe;
	endsequence

	// code in the unassigned stretch between the groups and the die sensor
	sequence sSpareCode;
		liveQ && req.code > `ACS_CH_GROUP_LAST && req.code < `ACS_CH_DIE_TEMP;
	endsequence

	a_onehot_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
		$onehot(sel.sel)) else $error("select not one-hot");
	a_binary_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
		liveQ |=> sel.sel[$past(req.code)]) else $error("wrong channel bit");
	a_supply_chan: assert property (@(posedge sys_clk) disable iff (!nrst)
		sCodeIs(0) |=> sel.src == ACS_SRC_SUPPLY && sel.sel[0]) else $error("ch0 not supply");
	a_die_chan: assert property (@(posedge sys_clk) disable iff (!nrst)
		sCodeIs(31) |=> sel.src == ACS_SRC_DIETEMP && !sel.groupValid) else $error("ch31 not die");
	a_fixed_ends: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.groupValid |-> !sel.sel[0] && !sel.sel[31]) else $error("fixed channel in group");
	a_group_volt: assert property (@(posedge sys_clk) disable iff (!nrst)
		sCodeIs(13) |=> sel.src == ACS_SRC_VOLT && sel.group == 3'h4) else $error("ch13 map");
	a_group_therm: assert property (@(posedge sys_clk) disable iff (!nrst)
		sCodeIs(6) |=> sel.src == ACS_SRC_THERM && sel.group == 3'h1) else $error("ch6 map");
	a_die_strobe: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.dieTempStrobe |-> $past(req.tempStrobe) && sel.sel[31]) else $error("die strobe cause");

	////////////////////////////////////////////////////////////////
	// per-channel checks: each select bit follows its own code only,
	// so a stuck or crossed bit shows up on the channel that owns it
	genvar gc;
	generate
		for (gc = 0; gc < `ACS_NUM_CHANNELS; gc++) begin : gChanChk
			a_chan_taken: assert property (@(posedge sys_clk) disable iff (!nrst)
				sCodeIs(gc) |=> sel.sel[gc]) else $error("channel bit not set");
			a_chan_dropped: assert property (@(posedge sys_clk) disable iff (!nrst)
				liveQ && req.code != 5'(gc) |=> !sel.sel[gc]) else $error("stale channel bit");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// per-group checks: three inputs per group, in voltage, current,
	// thermal order; the group index must match the channel's position
	genvar gg;
	generate
		for (gg = 0; gg < `ACS_NUM_GROUPS; gg++) begin : gGroupChk
			a_grp_voltage: assert property (@(posedge sys_clk) disable iff (!nrst)
				sGroupCode(gg, 0) |=> sel.src == ACS_SRC_VOLT && sel.group == 3'(gg) && sel.groupValid)
				else $error("group voltage input misplaced");
			a_grp_current: assert property (@(posedge sys_clk) disable iff (!nrst)
				sGroupCode(gg, 1) |=> sel.src == ACS_SRC_CURR && sel.group == 3'(gg) && sel.groupValid)
				else $error("group current input misplaced");
			a_grp_thermal: assert property (@(posedge sys_clk) disable iff (!nrst)
				sGroupCode(gg, 2) |=> sel.src == ACS_SRC_THERM && sel.group == 3'(gg) && sel.groupValid)
				else $error("group thermal input misplaced");
			// a strobe on the group's thermal input must reach it, and not the die sensor
			a_grp_strobe: assert property (@(posedge sys_clk) disable iff (!nrst)
				sStrobeWith(3 * gg + 3) |=> sel.groupTempStrobe && !sel.dieTempStrobe)
				else $error("group thermal strobe lost");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// fixed channels and the spare stretch; the spare codes still
	// select their mux input but must never claim a group
	a_supply_alone: assert property (@(posedge sys_clk) disable iff (!nrst)
		sCodeIs(0) |=> !sel.groupValid && sel.group == 3'h0 && !sel.groupTempStrobe)
		else $error("supply channel carries a group");
	a_spare_chan: assert property (@(posedge sys_clk) disable iff (!nrst)
		sSpareCode |=> sel.src == ACS_SRC_SPARE && !sel.groupValid && sel.group == 3'h0)
		else $error("spare channel typed as a source");
	a_group_range: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.groupValid |-> sel.group < 3'(`ACS_NUM_GROUPS))
		else $error("group index out of range");
	a_valid_type: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.groupValid |-> sel.src inside {ACS_SRC_VOLT, ACS_SRC_CURR, ACS_SRC_THERM})
		else $error("group flag on a non-group source");

	////////////////////////////////////////////////////////////////
	// temperature strobes: each strobe output has exactly one cause,
	// so a strobe can never sample a sensor that is not selected
	a_strobe_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		sStrobeIdle |=> !sel.dieTempStrobe && !sel.groupTempStrobe)
		else $error("strobe without request");
	a_die_strobe_on: assert property (@(posedge sys_clk) disable iff (!nrst)
		sStrobeWith(31) |=> sel.dieTempStrobe && !sel.groupTempStrobe)
		else $error("die strobe lost");
	a_die_strobe_off: assert property (@(posedge sys_clk) disable iff (!nrst)
		liveQ && req.code != `ACS_CH_DIE_TEMP |=> !sel.dieTempStrobe)
		else $error("die strobe on another channel");
	a_die_strobe_src: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.dieTempStrobe |-> sel.src == ACS_SRC_DIETEMP)
		else $error("die strobe with wrong source");
	a_grp_strobe_src: assert property (@(posedge sys_clk) disable iff (!nrst)
		sel.groupTempStrobe |-> $past(req.tempStrobe) && sel.src == ACS_SRC_THERM && sel.groupValid)
		else $error("group strobe cause");
	a_strobe_exclusive: assert property (@(posedge sys_clk) disable iff (!nrst)
		!(sel.dieTempStrobe && sel.groupTempStrobe))
		else $error("both strobes raised");
endmodule // acs_channel_select
`default_nettype wire

/* File: bench/acs_fabric_model.sv */
/*
 user fabric model driving the channel request.
 assumes the bench changes code and strobe only between conversions.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_fabric_model (
	input wire logic [4:0] code,
	input wire logic strobe,
	output acs_pkg::acs_req_s req
);
	import acs_pkg::*;
	// binary code and strobe level held for a whole conversion
	assign req = '{code: code, tempStrobe: strobe};
endmodule // acs_fabric_model
`default_nettype wire

/* File: bench/tb_adc_channel_select.sv */
/*
 self-checking bench for the converter channel select.
 assumes the fabric model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_adc_channel_select;
	import acs_pkg::*;
	logic sysClk = 1'b0;
	logic nrst = 1'b0;
	logic stb = 1'b1;
	logic [4:0] code = 5'h1f;
	acs_req_s req;
	acs_sel_s sel;
	int failures = 0;
	int check_count = 0;
	acs_fabric_model fab (.code(code), .strobe(stb), .req(req));
	acs_channel_select uut (.sys_clk(sysClk), .nrst(nrst), .req(req), .sel(sel));
	initial forever #12.5 sysClk = ~sysClk;
	//////////////////////////////////////////////////////////////
	// compare and report
	task automatic check(acs_sel_s seen, acs_sel_s exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// expected selection worked out from the channel map
	function automatic acs_sel_s expSel(logic [4:0] c, logic s);
		acs_sel_s e;
		e = '0;
		e.sel = 32'h0000_0001 << c;
		if (c == 5'h00) e.src = ACS_SRC_SUPPLY;
		else if (c == 5'h1f) e.src = ACS_SRC_DIETEMP;
		else if (c > 5'h0f) e.src = ACS_SRC_SPARE;
		else begin
			e.groupValid = 1'b1;
			e.group = 3'((c - 1) / 3);
			e.src = (c - 1) % 3 == 0 ? ACS_SRC_VOLT : ((c - 1) % 3 == 1 ? ACS_SRC_CURR : ACS_SRC_THERM);
		end
		e.dieTempStrobe = s && c == 5'h1f;
		e.groupTempStrobe = s && e.src == ACS_SRC_THERM;
		return e;
	endfunction
	task automatic results;
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// every code with strobe low, then high
	task automatic test_sweep;
		for (int i = 0; i < 64; i++) begin
			@(posedge sysClk) code <= 5'(i);
			stb <= i[5];
			@(posedge sysClk) #1 check(sel, expSel(5'(i), i[5]));
		end
	endtask
	// asynchronous reset in mid-run, request held on die sensor
	task automatic test_reset;
		@(posedge sysClk) code <= 5'h1f;
		stb <= 1'b1;
		#5 nrst <= 1'b0;
		#1 check(sel, expSel(5'h00, 1'b0));
		@(posedge sysClk) nrst <= 1'b1;
		@(posedge sysClk) #1 check(sel, expSel(5'h1f, 1'b1));
	endtask
	//////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge sysClk);
		check(sel, expSel(5'h00, 1'b0));
		nrst <= 1'b1;
		test_sweep();
		test_reset();
		results();
	end
	// watchdog
	initial begin
		#20000;
		failures++;
		results();
	end
endmodule // tb_adc_channel_select
`default_nettype wire
